/* core/alias_remap.sv */
// What this block does
// - seven-bit physical address per slot, bits 7:1
// - eight slots, each alias paired with physical
// - alias hit rewrites address, forwards over channel
// - seven-bit alias per slot, compared on address
// - slot n alias maps to slot n physical
// - zero alias disables that slot
// - alias bit 0 enables local write auto-ack
// - auto-ack ignores lock and remote acknowledge
`include "alias_remap_regs.svh"
`default_nettype none

module alias_remap
  import alias_remap_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // local i2c target front end
  input wire logic loc_addr_valid_i,
  input wire logic loc_data_valid_i,
  input wire logic loc_rdreq_i,
  input wire logic loc_stop_i,
  input wire logic [7:0] loc_byte_i,
  output logic loc_sel_o,
  output logic loc_ack_valid_o,
  output logic loc_ack_o,
  output logic [7:0] loc_rdata_o,
  // control channel toward the remote deserializer
  input wire logic lock_i,
  input wire logic bcc_ack_valid_i,
  input wire logic bcc_ack_i,
  input wire logic [7:0] bcc_rdata_i,
  output logic bcc_valid_o,
  output bcc_kind_e bcc_kind_o,
  output logic [7:0] bcc_byte_o
);

  // ---------------------------------------------------------------------------
  // slot tables
  // ---------------------------------------------------------------------------
  logic [`NUM_SLOTS-1:0][6:0] phys_q;
  logic [`NUM_SLOTS-1:0][6:0] alias_q;
  logic [`NUM_SLOTS-1:0] auto_q;

  // ---------------------------------------------------------------------------
  // transaction state
  // ---------------------------------------------------------------------------
  remap_state_e state_q;
  remap_state_e state_d;
  slot_t slot_q;
  logic rd_q;
  logic auto_txn_q;
  logic last_ack_q;
  logic match_hit;
  slot_t match_slot;
  logic [7:0] remapped;
  logic addr_auto;
  logic addr_take;

  // register index helpers, shared by write and read decode
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'(`NUM_SLOTS));
  endfunction : in_range

  function automatic slot_t slot_of(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[2:0];
  endfunction : slot_of

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  generate
    for (genvar g = 0; g < `NUM_SLOTS; g++)
    begin : g_slot
      // physical address field; bit 0 is not stored at all
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          phys_q[g] <= `SLOT_RESET;
        end
        else if (reg_we_i && in_range(reg_addr_i, `REMOTE_PHYS_ADDR_BASE)
                 && (slot_of(reg_addr_i, `REMOTE_PHYS_ADDR_BASE) == slot_t'(g)))
        begin
          phys_q[g] <= reg_wdata_i[`ADDR7_MSB:`ADDR7_LSB];
        end
      end

      // alias field and its auto-ack enable share one byte
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          alias_q[g] <= `SLOT_RESET;
          auto_q[g] <= `AUTO_ACK_RESET;
        end
        else if (reg_we_i && in_range(reg_addr_i, `ALIAS_MATCH_BASE)
                 && (slot_of(reg_addr_i, `ALIAS_MATCH_BASE) == slot_t'(g)))
        begin
          alias_q[g] <= reg_wdata_i[`ADDR7_MSB:`ADDR7_LSB];
          auto_q[g] <= reg_wdata_i[`AUTO_ACK_BIT];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------------------
  // data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (!reg_re_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (in_range(reg_addr_i, `REMOTE_PHYS_ADDR_BASE))
    begin
      // bit 0 of a physical register always reads zero
      reg_rdata_o <= {phys_q[slot_of(reg_addr_i, `REMOTE_PHYS_ADDR_BASE)], 1'b0};
    end
    else if (in_range(reg_addr_i, `ALIAS_MATCH_BASE))
    begin
      reg_rdata_o <= {alias_q[slot_of(reg_addr_i, `ALIAS_MATCH_BASE)],
                      auto_q[slot_of(reg_addr_i, `ALIAS_MATCH_BASE)]};
    end
    else if (reg_addr_i == `REMAP_STATUS)
    begin
      reg_rdata_o <= {2'b00, auto_txn_q, last_ack_q, slot_q, loc_sel_o};
    end
    else
    begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // alias decode
  // ---------------------------------------------------------------------------
  alias_matcher u_match (
    .addr_i (loc_byte_i[`ADDR7_MSB:`ADDR7_LSB]),
    .alias_i (alias_q),
    .hit_o (match_hit),
    .slot_o (match_slot)
  );

  // same slot index picks the physical address, rw bit passes untouched
  assign remapped = {phys_q[match_slot], loc_byte_i[`RW_BIT]};

  // auto-ack applies to write transactions only
  assign addr_auto = auto_q[match_slot] && !loc_byte_i[`RW_BIT];

  // an address byte is claimed only when an enabled slot matches
  assign addr_take = loc_addr_valid_i && match_hit && (state_q != ST_ADDR_ACK);

  // ---------------------------------------------------------------------------
  // state machine
  // ---------------------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (addr_take)
        begin
          // a dead link fails the address at once unless auto-ack covers it
          state_d = (addr_auto || !lock_i) ? (addr_auto ? ST_XFER : ST_IDLE)
                                           : ST_ADDR_ACK;
        end
      end
      ST_ADDR_ACK:
      begin
        if (loc_stop_i)
        begin
          state_d = ST_IDLE;
        end
        else if (!lock_i)
        begin
          state_d = ST_IDLE;
        end
        else if (bcc_ack_valid_i)
        begin
          state_d = bcc_ack_i ? ST_XFER : ST_IDLE;
        end
      end
      ST_XFER:
      begin
        if (loc_stop_i)
        begin
          state_d = ST_IDLE;
        end
        else if (loc_addr_valid_i)
        begin
          // repeated start: re-decode, a miss drops the path
          state_d = !addr_take ? ST_IDLE
                  : (addr_auto ? ST_XFER : (lock_i ? ST_ADDR_ACK : ST_IDLE));
        end
        else if (loc_rdreq_i && rd_q)
        begin
          state_d = ST_DATA_ACK;
        end
        else if (loc_data_valid_i && !rd_q && !auto_txn_q)
        begin
          state_d = ST_DATA_ACK;
        end
      end
      ST_DATA_ACK:
      begin
        if (loc_stop_i || !lock_i)
        begin
          state_d = (loc_stop_i) ? ST_IDLE : ST_XFER;
        end
        else if (bcc_ack_valid_i)
        begin
          state_d = ST_XFER;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // per-transaction context, captured when an address is claimed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      slot_q <= 3'h0;
      rd_q <= 1'b0;
      auto_txn_q <= 1'b0;
    end
    else if (addr_take && (state_q != ST_DATA_ACK))
    begin
      slot_q <= match_slot;
      rd_q <= loc_byte_i[`RW_BIT];
      auto_txn_q <= addr_auto;
    end
  end

  // level telling the local bus that this path owns the transaction
  assign loc_sel_o = (state_q != ST_IDLE);

  // ---------------------------------------------------------------------------
  // forwarding toward the control channel
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bcc_valid_o <= 1'b0;
      bcc_kind_o <= KIND_STOP;
      bcc_byte_o <= 8'h00;
    end
    else if (addr_take && (state_q == ST_IDLE || state_q == ST_XFER))
    begin
      bcc_valid_o <= 1'b1;
      bcc_kind_o <= KIND_ADDR;
      bcc_byte_o <= remapped;
    end
    else if (loc_stop_i && loc_sel_o)
    begin
      bcc_valid_o <= 1'b1;
      bcc_kind_o <= KIND_STOP;
      bcc_byte_o <= 8'h00;
    end
    else if (state_q == ST_XFER && loc_data_valid_i && !rd_q)
    begin
      bcc_valid_o <= 1'b1;
      bcc_kind_o <= KIND_DATA;
      bcc_byte_o <= loc_byte_i;
    end
    else if (state_q == ST_XFER && loc_rdreq_i && rd_q)
    begin
      bcc_valid_o <= 1'b1;
      bcc_kind_o <= KIND_RDREQ;
      bcc_byte_o <= 8'h00;
    end
    else
    begin
      bcc_valid_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // acknowledge toward the local controller
  // ---------------------------------------------------------------------------
  // auto-ack answers a cycle after the byte, never waiting on the link
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loc_ack_valid_o <= 1'b0;
      loc_ack_o <= 1'b0;
      loc_rdata_o <= 8'h00;
    end
    else if (addr_take && (state_q == ST_IDLE || state_q == ST_XFER))
    begin
      // auto-ack wins over lock state and remote answer
      loc_ack_valid_o <= addr_auto || !lock_i;
      loc_ack_o <= addr_auto;
    end
    else if (state_q == ST_XFER && loc_data_valid_i && !rd_q && auto_txn_q)
    begin
      loc_ack_valid_o <= 1'b1;
      loc_ack_o <= 1'b1;
    end
    else if ((state_q == ST_ADDR_ACK || state_q == ST_DATA_ACK) && !loc_stop_i
             && (!lock_i || bcc_ack_valid_i))
    begin
      // lost lock counts as a not-acknowledge
      loc_ack_valid_o <= 1'b1;
      loc_ack_o <= lock_i && bcc_ack_i;
      if (state_q == ST_DATA_ACK && rd_q && lock_i)
      begin
        loc_rdata_o <= bcc_rdata_i;
      end
    end
    else
    begin
      loc_ack_valid_o <= 1'b0;
    end
  end

  // last answer given, kept for status reads
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_ack_q <= 1'b0;
    end
    else if (loc_ack_valid_o)
    begin
      last_ack_q <= loc_ack_o;
    end
  end

endmodule : alias_remap

`default_nettype wire

/* include/alias_remap_regs.svh */
`ifndef ALIAS_REMAP_REGS_SVH
`define ALIAS_REMAP_REGS_SVH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
// physical address slot n sits at PHYS_BASE + n, alias slot n at ALIAS_BASE + n
`define REMOTE_PHYS_ADDR_BASE 8'h39
`define REMOTE_PHYS_ADDR_6 8'h3f
`define REMOTE_PHYS_ADDR_7 8'h40
`define ALIAS_MATCH_BASE 8'h41
`define ALIAS_MATCH_ADDR_0 8'h41
`define ALIAS_MATCH_ADDR_1 8'h42
`define ALIAS_MATCH_ADDR_2 8'h43
`define REMAP_STATUS 8'h50

// ---------------------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------------------
`define ADDR7_MSB 7
`define ADDR7_LSB 1
`define AUTO_ACK_BIT 0
`define RW_BIT 0
`define SLOT_RESET 7'h00
`define AUTO_ACK_RESET 1'b0
`define NUM_SLOTS 8
`define STAT_SEL_BIT 0
`define STAT_SLOT_LSB 1
`define STAT_SLOT_MSB 3
`define STAT_ACK_BIT 4
`define STAT_AUTO_BIT 5

`endif

/* include/alias_remap_pkg.sv */
`default_nettype none

package alias_remap_pkg;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef logic [6:0] addr7_t;
  typedef logic [2:0] slot_t;

  // transaction phase of the pass-through path
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_ADDR_ACK = 2'b01,
    ST_XFER     = 2'b10,
    ST_DATA_ACK = 2'b11
  } remap_state_e;

  // item kinds handed to the control channel
  typedef enum logic [1:0] {
    KIND_ADDR  = 2'b00,
    KIND_DATA  = 2'b01,
    KIND_RDREQ = 2'b10,
    KIND_STOP  = 2'b11
  } bcc_kind_e;

endpackage : alias_remap_pkg

`default_nettype wire

/* core/alias_matcher.sv */
`include "alias_remap_regs.svh"
`default_nettype none

module alias_matcher
  import alias_remap_pkg::*;
(
  // address under test
  input wire addr7_t addr_i,
  // per-slot alias table
  input wire logic [`NUM_SLOTS-1:0][6:0] alias_i,
  // result
  output logic hit_o,
  output slot_t slot_o
);

  logic [`NUM_SLOTS-1:0] hit_vec;

  // lowest slot wins; duplicate aliases are a software error, not a hang
  function automatic slot_t first_hit(input logic [`NUM_SLOTS-1:0] v);
    slot_t s;
    s = 3'h0;
    for (int i = `NUM_SLOTS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        s = slot_t'(i);
      end
    end
    return s;
  endfunction : first_hit

  // ---------------------------------------------------------------------------
  // per-slot compare
  // ---------------------------------------------------------------------------
  generate
    for (genvar g = 0; g < `NUM_SLOTS; g++)
    begin : g_cmp
      // a zero alias never matches, so the slot is closed
      assign hit_vec[g] = (alias_i[g] != `SLOT_RESET) && (alias_i[g] == addr_i);
    end
  endgenerate

  // hit and index of the matching slot
  assign hit_o = |hit_vec;
  assign slot_o = first_hit(hit_vec);

endmodule : alias_matcher

`default_nettype wire

/* dv/alias_remap_checker.sv */
`default_nettype none

module alias_remap_checker
  import alias_remap_pkg::*;
(
  // clock and register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reg_re_i,
  input wire logic [7:0] reg_rdata_o,
  // local and channel side
  input wire logic loc_addr_valid_i,
  input wire logic loc_data_valid_i,
  input wire logic loc_rdreq_i,
  input wire logic loc_stop_i,
  input wire logic [7:0] loc_byte_i,
  input wire logic loc_sel_o,
  input wire logic loc_ack_valid_o,
  input wire logic [7:0] loc_rdata_o,
  input wire logic bcc_valid_o,
  input wire bcc_kind_e bcc_kind_o,
  input wire logic [7:0] bcc_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero");
  a_addr_keep_rw: assert property (bcc_valid_o && bcc_kind_o == KIND_ADDR
    |-> $past(loc_addr_valid_i) && bcc_byte_o[0] == $past(loc_byte_i[0]))
    else $error("address item without cause");
  a_zero_miss: assert property (loc_addr_valid_i && loc_byte_i[7:1] == 7'h00
    && !loc_sel_o |=> !loc_sel_o)
    else $error("zero address selected");
  a_data_fwd: assert property (bcc_valid_o && bcc_kind_o == KIND_DATA
    |-> $past(loc_data_valid_i) && bcc_byte_o == $past(loc_byte_i))
    else $error("data item mismatch");
  a_rdreq_fwd: assert property (bcc_valid_o && bcc_kind_o == KIND_RDREQ
    |-> $past(loc_rdreq_i) && bcc_byte_o == 8'h00)
    else $error("read item mismatch");
  a_stop_release: assert property (loc_stop_i && loc_sel_o
    |=> bcc_valid_o && bcc_kind_o == KIND_STOP && !loc_sel_o)
    else $error("stop not forwarded");
  a_sel_on_addr: assert property ($rose(loc_sel_o)
    |-> bcc_valid_o && bcc_kind_o == KIND_ADDR && $past(loc_addr_valid_i))
    else $error("select without address");
  a_ack_pulse: assert property (loc_ack_valid_o |=> !loc_ack_valid_o)
    else $error("ack longer than a cycle");
  a_rdata_hold: assert property (!loc_ack_valid_o |-> $stable(loc_rdata_o))
    else $error("read byte moved");

  // main scenarios reached
  c_addr: cover property (bcc_valid_o && bcc_kind_o == KIND_ADDR);
  c_read: cover property (loc_rdreq_i ##[1:20] loc_ack_valid_o);
  c_stop: cover property (loc_stop_i && loc_sel_o);
endmodule : alias_remap_checker

bind alias_remap alias_remap_checker u_chk (.clk_i, .rst_i, .reg_re_i, .reg_rdata_o,
  .loc_addr_valid_i, .loc_data_valid_i, .loc_rdreq_i, .loc_stop_i, .loc_byte_i,
  .loc_sel_o, .loc_ack_valid_o, .loc_rdata_o, .bcc_valid_o, .bcc_kind_o, .bcc_byte_o);

`default_nettype wire

/* dv/remote_deser_model.sv */
`default_nettype none

module remote_deser_model
  import alias_remap_pkg::*;
(
  // clock and items in
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic valid_i,
  input wire bcc_kind_e kind_i,
  // knobs: extra delay, refuse
  input wire logic [3:0] dly_i,
  input wire logic nack_i,
  // answers
  output logic ack_valid_o,
  output logic ack_o,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic pend_q;
  logic [3:0] cnt_q;

  // one answer per item except stop, dly_i cycles late
  always_ff @(posedge clk_i)
  begin
    ack_valid_o <= 1'b0;
    if (rst_i)
      pend_q <= 1'b0;
    else if (valid_i && kind_i != KIND_STOP)
    begin
      pend_q <= 1'b1;
      cnt_q <= dly_i;
    end
    else if (pend_q && cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else if (pend_q)
    begin
      pend_q <= 1'b0;
      ack_valid_o <= 1'b1;
    end
  end

  // released lines flip so a stale value never looks valid
  assign ack_o = ack_valid_o ? ~nack_i : nack_i;
  assign rdata_o = ack_valid_o ? 8'h3c : 8'hc3;
endmodule : remote_deser_model

`default_nettype wire

/* dv/remote_i2c_alias_remap_test.sv */
`include "alias_remap_regs.svh"
`default_nettype none

module remote_i2c_alias_remap_test import alias_remap_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_i, rst_i, reg_we_i, reg_re_i, lock_i, nack_en;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, loc_byte_i, loc_rdata_o;
  logic [3:0] pls, dly; // pls: stop, rdreq, data, addr
  logic loc_sel_o, loc_ack_valid_o, loc_ack_o, bcc_ack_valid_i, bcc_ack_i, bcc_valid_o;
  logic [7:0] bcc_rdata_i, bcc_byte_o;
  bcc_kind_e bcc_kind_o;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;

  alias_remap uut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
    .reg_rdata_o, .loc_addr_valid_i(pls[0]), .loc_data_valid_i(pls[1]),
    .loc_rdreq_i(pls[2]), .loc_stop_i(pls[3]), .loc_byte_i, .loc_sel_o,
    .loc_ack_valid_o, .loc_ack_o, .loc_rdata_o, .lock_i, .bcc_ack_valid_i, .bcc_ack_i,
    .bcc_rdata_i, .bcc_valid_o, .bcc_kind_o, .bcc_byte_o);
  remote_deser_model far (.clk_i, .rst_i, .valid_i(bcc_valid_o), .kind_i(bcc_kind_o),
    .dly_i(dly), .nack_i(nack_en), .ack_valid_o(bcc_ack_valid_i), .ack_o(bcc_ack_i),
    .rdata_o(bcc_rdata_i));

  // ---------------------------------------------------------------
  // drivers and compare
  // ---------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // the run needs under 2000 cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd

  // one local pulse: 0 addr, 1 data, 2 rdreq, 3 stop
  task automatic lp(input int k, input logic [7:0] b);
    @(posedge clk_i);
    loc_byte_i <= b;
    pls <= 4'h1 << k;
    @(posedge clk_i);
    pls <= 4'h0;
    #1;
  endtask : lp

  // waits a bounded time for the local answer
  task automatic wack(input logic e);
    for (int n = 0; n < 20 && loc_ack_valid_o !== 1'b1; n++)
      @(posedge clk_i) #1;
    chk({6'h0, loc_ack_valid_o, loc_ack_o}, {6'h0, 1'b1, e});
  endtask : wack

  // address, then one data or read byte when acknowledged, then stop through slot n
  task automatic xfer(input int n, input logic rw, input logic e);
    lp(0, {7'h20 + 7'(n), rw});
    chk({5'h0, bcc_valid_o, bcc_kind_o}, {5'h0, 1'b1, KIND_ADDR});
    chk(bcc_byte_o, {7'h48 + 7'(n), rw});
    wack(e);
    if (e && rw)
    begin
      lp(2, 8'h00);
      wack(1'b1);
      chk(loc_rdata_o, 8'h3c);
    end
    else if (e)
    begin
      lp(1, 8'h96 ^ 8'(n));
      chk(bcc_byte_o, 8'h96 ^ 8'(n));
      wack(1'b1);
    end
    lp(3, 8'h00);
    chk({7'h0, loc_sel_o}, 8'h00);
  endtask : xfer

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [7:0] d;
    for (int a = 8'h39; a <= 8'h48; a++)
    begin
      rd(8'(a), d);
      chk(d, 8'h00);
    end
    for (int n = 0; n < 8; n++)
    begin
      wr(`REMOTE_PHYS_ADDR_BASE + 8'(n), {7'h48 + 7'(n), 1'b1});
      wr(`ALIAS_MATCH_BASE + 8'(n), {7'h20 + 7'(n), 1'b0});
    end
    for (int n = 0; n < 8; n++)
    begin
      rd(`REMOTE_PHYS_ADDR_BASE + 8'(n), d);
      chk(d, {7'h48 + 7'(n), 1'b0});
      rd(`ALIAS_MATCH_BASE + 8'(n), d);
      chk(d, {7'h20 + 7'(n), 1'b0});
    end
    wr(8'h60, 8'hff);
    rd(8'h60, d);
    chk(d, 8'h00);
  endtask : t_regs

  // every slot once, odd slots read with a slow far end
  task automatic t_remap();
    for (int n = 0; n < 8; n++)
    begin
      dly <= n[0] ? 4'h6 : 4'h0;
      xfer(n, n[0], 1'b1);
    end
  endtask : t_remap

  // debug auto-ack with link down and far end refusing
  task automatic t_auto();
    logic [7:0] d;
    dly <= 4'h0;
    wr(`ALIAS_MATCH_BASE + 8'h03, {7'h23, 1'b1});
    lock_i <= 1'b0;
    nack_en <= 1'b1;
    xfer(3, 1'b0, 1'b1);
    // status: auto-acked, last ack high, slot 3, path released
    rd(`REMAP_STATUS, d);
    chk(d, 8'h36);
    // reads are never auto-acked, so a dead link refuses them
    xfer(3, 1'b1, 1'b0);
    wr(`ALIAS_MATCH_BASE + 8'h03, {7'h23, 1'b0});
    xfer(3, 1'b0, 1'b0);
    @(posedge clk_i);
    lock_i <= 1'b1;
    xfer(2, 1'b0, 1'b0);
    nack_en <= 1'b0;
  endtask : t_auto

  // a cleared alias no longer matches, zero never does
  task automatic t_off();
    wr(`ALIAS_MATCH_BASE + 8'h04, 8'h00);
    lp(0, {7'h24, 1'b0});
    chk({5'h0, loc_sel_o, bcc_valid_o, loc_ack_valid_o}, 8'h00);
    lp(0, 8'h00);
    chk({5'h0, loc_sel_o, bcc_valid_o, loc_ack_valid_o}, 8'h00);
  endtask : t_off

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    rst_i = 1'b1;
    {reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, pls, loc_byte_i} = '0;
    {lock_i, nack_en, dly} = 6'h20;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_remap();
    t_auto();
    t_off();
    end_of_test();
  end
endmodule : remote_i2c_alias_remap_test

`default_nettype wire
